// ### verilog/tfs_pkg.sv
package tfs_pkg;

	// ==========================================
	// Channel order: 0 remote 1, 1 local, 2 remote 2
	localparam int unsigned NUM_CH   = 3;
	localparam int unsigned DATA_W   = 8;

	// ==========================================
	// Register indices, byte address is index times four
	localparam logic [6:0] IDX_LIMIT_R1   = 7'h6a;
	localparam logic [6:0] IDX_LIMIT_LOC  = 7'h6b;
	localparam logic [6:0] IDX_LIMIT_R2   = 7'h6c;
	localparam logic [6:0] IDX_HYST_R1LOC = 7'h6d;
	localparam logic [6:0] IDX_HYST_R2    = 7'h6e;
	localparam logic [6:0] IDX_XOR_TEST   = 7'h6f;
	localparam logic [6:0] IDX_OFS_R1     = 7'h70;
	localparam logic [6:0] IDX_OFS_LOC    = 7'h71;
	localparam logic [6:0] IDX_OFS_R2     = 7'h72;
	localparam logic [6:0] IDX_LOCK       = 7'h7a;
	localparam logic [6:0] IDX_STATUS     = 7'h7b;
	localparam logic [6:0] IDX_CORR_R1    = 7'h7c;
	localparam logic [6:0] IDX_CORR_LOC   = 7'h7d;
	localparam logic [6:0] IDX_CORR_R2    = 7'h7e;

	// ==========================================
	// Reset values
	localparam logic [7:0] RST_LIMIT      = 8'h64;
	localparam logic [7:0] RST_HYST_R1LOC = 8'h44;
	localparam logic [7:0] RST_HYST_R2    = 8'h40;
	localparam logic [7:0] RST_XOR_TEST   = 8'h00;
	localparam logic [7:0] RST_OFS        = 8'h00;

	// ==========================================
	// Field positions and codes
	localparam int unsigned XOR_ON_BIT    = 0;
	localparam int unsigned LOCK_BIT      = 0;
	localparam int unsigned ST_OVR_BIT    = 0;
	localparam int unsigned ST_TRIP_LSB   = 1;
	localparam int unsigned ST_FAN_LSB    = 4;
	localparam int unsigned HYST_HI_LSB   = 4;
	localparam logic [7:0] LIMIT_DISABLE  = 8'h80;
	localparam logic [4:0] RELEASE_MARGIN = 5'h04;

	typedef enum logic {
		TFS_OVR_IDLE,
		TFS_OVR_ACTIVE
	} tfs_ovr_e;

endpackage

// ### verilog/tfs_chan_if.sv
`timescale 1ns/1ps

interface tfs_chan_if;
	logic [7:0] raw_temp;
	logic       sample;
	logic [7:0] offset;
	logic [7:0] limit;
	logic [7:0] fan_start;
	logic [3:0] hyst;
	logic [7:0] corr_temp;
	logic       trip;
	logic       fan_run;

	modport bank (
		output raw_temp, sample, offset, limit, fan_start, hyst,
		input  corr_temp, trip, fan_run
	);
	modport chan (
		input  raw_temp, sample, offset, limit, fan_start, hyst,
		output corr_temp, trip, fan_run
	);
endinterface

// ### verilog/tfs_channel.sv
`timescale 1ns/1ps

module tfs_channel
	import tfs_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_i,
	tfs_chan_if.chan  ch
);

	logic signed [8:0] sum;
	logic signed [7:0] corr;
	logic signed [9:0] lim_rel;
	logic signed [9:0] fan_off;
	tfs_ovr_e          ovr_q;
	logic [7:0]        corr_q;
	logic              fan_q;

	// ==========================================
	// Offset correction, saturated to one byte
	always_comb begin
		sum = $signed({ch.raw_temp[7], ch.raw_temp}) + $signed({ch.offset[7], ch.offset});
		if (sum > 9'sd127)
			corr = 8'sh7f;
		else if (sum < -9'sd128)
			corr = 8'sh80;
		else
			corr = sum[7:0];
		lim_rel = $signed({{2{ch.limit[7]}}, ch.limit}) - $signed({5'h00, RELEASE_MARGIN});
		fan_off = $signed({{2{ch.fan_start[7]}}, ch.fan_start}) - $signed({6'h00, ch.hyst});
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			corr_q <= 8'h00;
		else if (ch.sample)
			corr_q <= corr;
	end

	// ==========================================
	// Critical override, judged on each fresh result
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ovr_q <= TFS_OVR_IDLE;
		end else if (ch.limit == LIMIT_DISABLE) begin
			ovr_q <= TFS_OVR_IDLE;
		end else if (ch.sample) begin
			case (ovr_q)
				TFS_OVR_IDLE: begin
					if (corr > $signed(ch.limit))
						ovr_q <= TFS_OVR_ACTIVE;
				end
				TFS_OVR_ACTIVE: begin
					if ($signed({{2{corr[7]}}, corr}) < lim_rel)
						ovr_q <= TFS_OVR_IDLE;
				end
				default: ovr_q <= TFS_OVR_IDLE;
			endcase
		end
	end

	// ==========================================
	// Fan-run decision with hysteresis below fan start
	always_ff @(posedge clk_i) begin
		if (rst_i)
			fan_q <= 1'b0;
		else if (ch.sample) begin
			if (corr > $signed(ch.fan_start))
				fan_q <= 1'b1;
			else if ($signed({{2{corr[7]}}, corr}) <= fan_off)
				fan_q <= 1'b0;
		end
	end

	assign ch.corr_temp = corr_q;
	assign ch.trip      = (ovr_q == TFS_OVR_ACTIVE);
	assign ch.fan_run   = fan_q;

endmodule

// ### verilog/tfs_regs.sv
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ps


module tfs_regs
	import tfs_pkg::*;
#(
	parameter int unsigned ADR_W = 9
) (
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	input  wire logic                     wb_cyc_i,
	input  wire logic                     wb_stb_i,
	input  wire logic                     wb_we_i,
	input  wire logic [ADR_W-1:0]         wb_adr_i,
	input  wire logic [3:0]               wb_sel_i,
	input  wire logic [31:0]              wb_dat_i,
	output logic      [31:0]              wb_dat_o,
	output logic                          wb_ack_o,
	input  wire logic [NUM_CH*DATA_W-1:0] temp_i,
	input  wire logic [NUM_CH-1:0]        temp_valid_i,
	input  wire logic [NUM_CH*DATA_W-1:0] fan_start_i,
	output logic                          full_speed_o,
	output logic      [NUM_CH-1:0]        fan_min_run_o,
	output logic                          xor_test_on_o
);

	// Index bits 8:2 must exist on the address port
	if (ADR_W < 9) begin : g_adr_check
		$error("ADR_W too small for the register map");
	end

	// ==========================================
	// Register state
	logic [7:0]        limit_q [NUM_CH];
	logic [7:0]        ofs_q   [NUM_CH];
	logic [7:0]        hyst_r1loc_q;
	logic [7:0]        hyst_r2_q;
	logic              xor_test_on_q;
	logic              lock_q;
	logic              ack_q;
	logic [31:0]       rdata_q;
	logic              full_speed_q;
	logic [NUM_CH-1:0] fan_run_q;
	logic [31:0]       rdata_d;
	logic [6:0]        idx;
	logic              wr_en;
	logic [7:0]        wbyte;
	logic [NUM_CH-1:0] trip;
	logic [NUM_CH-1:0] fan_run;
	logic [7:0]        corr [NUM_CH];
	logic [3:0]        hyst [NUM_CH];

	// ==========================================
	// Bus decode
	assign idx   = wb_adr_i[8:2];
	assign wbyte = wb_dat_i[7:0];
	// Writes land on the request edge, the same edge that raises ack
	assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q && wb_sel_i[0];

	assign hyst[0] = hyst_r1loc_q[HYST_HI_LSB +: 4];
	assign hyst[1] = hyst_r1loc_q[3:0];
	assign hyst[2] = hyst_r2_q[HYST_HI_LSB +: 4];

	always_ff @(posedge clk_i) begin
		if (rst_i)
			ack_q <= 1'b0;
		else
			ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
	end

	// ==========================================
	// Critical limits
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < NUM_CH; i++)
				limit_q[i] <= RST_LIMIT;
		end else if (wr_en && !lock_q) begin
			case (idx)
				IDX_LIMIT_R1:  limit_q[0] <= wbyte;
				IDX_LIMIT_LOC: limit_q[1] <= wbyte;
				IDX_LIMIT_R2:  limit_q[2] <= wbyte;
				default: ;
			endcase
		end
	end

	// ==========================================
	// Hysteresis nibbles; not covered by the lock
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hyst_r1loc_q <= RST_HYST_R1LOC;
			hyst_r2_q    <= RST_HYST_R2;
		end else if (wr_en) begin
			case (idx)
				IDX_HYST_R1LOC: hyst_r1loc_q <= wbyte;
				IDX_HYST_R2:    hyst_r2_q    <= wbyte;
				default: ;
			endcase
		end
	end

	// ==========================================
	// Test enable and offsets
	always_ff @(posedge clk_i) begin
		if (rst_i)
			xor_test_on_q <= RST_XOR_TEST[XOR_ON_BIT];
		else if (wr_en && !lock_q && idx == IDX_XOR_TEST)
			xor_test_on_q <= wbyte[XOR_ON_BIT];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < NUM_CH; i++)
				ofs_q[i] <= RST_OFS;
		end else if (wr_en && !lock_q) begin
			case (idx)
				IDX_OFS_R1:  ofs_q[0] <= wbyte;
				IDX_OFS_LOC: ofs_q[1] <= wbyte;
				IDX_OFS_R2:  ofs_q[2] <= wbyte;
				default: ;
			endcase
		end
	end

	// ==========================================
	// Lock: set only, cleared by reset alone
	always_ff @(posedge clk_i) begin
		if (rst_i)
			lock_q <= 1'b0;
		else if (wr_en && idx == IDX_LOCK && wbyte[LOCK_BIT])
			lock_q <= 1'b1;
	end

	// ==========================================
	// Per-channel decision logic
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_ch
			tfs_chan_if cif ();

			assign cif.raw_temp  = temp_i[g*DATA_W +: DATA_W];
			assign cif.sample    = temp_valid_i[g];
			assign cif.offset    = ofs_q[g];
			assign cif.limit     = limit_q[g];
			assign cif.fan_start = fan_start_i[g*DATA_W +: DATA_W];
			assign cif.hyst      = hyst[g];
			assign corr[g]       = cif.corr_temp;
			assign trip[g]       = cif.trip;
			assign fan_run[g]    = cif.fan_run;

			tfs_channel u_chan (
				.clk_i (clk_i),
				.rst_i (rst_i),
				.ch    (cif.chan)
			);
		end
	endgenerate

	// ==========================================
	// Outputs; override wins over any fan setting downstream
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			full_speed_q <= 1'b0;
			fan_run_q    <= '0;
		end else begin
			full_speed_q <= |trip;
			fan_run_q    <= fan_run;
		end
	end

	// ==========================================
	// Read mux; unmapped indices read zero
	always_comb begin
		rdata_d = 32'h0000_0000;
		case (idx)
			IDX_LIMIT_R1:   rdata_d[7:0] = limit_q[0];
			IDX_LIMIT_LOC:  rdata_d[7:0] = limit_q[1];
			IDX_LIMIT_R2:   rdata_d[7:0] = limit_q[2];
			IDX_HYST_R1LOC: rdata_d[7:0] = hyst_r1loc_q;
			IDX_HYST_R2:    rdata_d[7:0] = hyst_r2_q;
			IDX_XOR_TEST:   rdata_d[XOR_ON_BIT] = xor_test_on_q;
			IDX_OFS_R1:     rdata_d[7:0] = ofs_q[0];
			IDX_OFS_LOC:    rdata_d[7:0] = ofs_q[1];
			IDX_OFS_R2:     rdata_d[7:0] = ofs_q[2];
			IDX_LOCK:       rdata_d[LOCK_BIT] = lock_q;
			IDX_STATUS: begin
				rdata_d[ST_OVR_BIT] = full_speed_q;
				rdata_d[ST_TRIP_LSB +: NUM_CH] = trip;
				rdata_d[ST_FAN_LSB +: NUM_CH] = fan_run_q;
			end
			IDX_CORR_R1:    rdata_d[7:0] = corr[0];
			IDX_CORR_LOC:   rdata_d[7:0] = corr[1];
			IDX_CORR_R2:    rdata_d[7:0] = corr[2];
			default:        rdata_d = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			rdata_q <= 32'h0000_0000;
		else if (wb_cyc_i && wb_stb_i && !ack_q)
			rdata_q <= rdata_d;
	end

	assign wb_ack_o      = ack_q;
	assign wb_dat_o      = rdata_q;
	assign full_speed_o  = full_speed_q;
	assign fan_min_run_o = fan_run_q;
	assign xor_test_on_o = xor_test_on_q;

endmodule

// ### verification/tfs_regs_checker.sv
`timescale 1ns/1ps

module tfs_regs_checker
	import tfs_pkg::*;
#(
	parameter int unsigned ADR_W = 9
) (
	input wire logic                     clk_i,
	input wire logic                     rst_i,
	input wire logic                     wb_cyc_i,
	input wire logic                     wb_stb_i,
	input wire logic                     wb_we_i,
	input wire logic [ADR_W-1:0]         wb_adr_i,
	input wire logic [3:0]               wb_sel_i,
	input wire logic [31:0]              wb_dat_i,
	input wire logic [31:0]              wb_dat_o,
	input wire logic                     wb_ack_o,
	input wire logic [NUM_CH*DATA_W-1:0] temp_i,
	input wire logic [NUM_CH-1:0]        temp_valid_i,
	input wire logic [NUM_CH*DATA_W-1:0] fan_start_i,
	input wire logic                     full_speed_o,
	input wire logic [NUM_CH-1:0]        fan_min_run_o,
	input wire logic                     xor_test_on_o
);
	// ==========================================
	// Helpers
	logic wr;
	assign wr = wb_cyc_i && wb_stb_i && wb_we_i;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Shadow of the lock bit, seen from the bus alone
	logic lock_seen_q;
	always_ff @(posedge clk_i) begin
		if (rst_i)
			lock_seen_q <= 1'b0;
		else if (wr && !wb_ack_o && wb_sel_i[0] && wb_adr_i[8:2] == IDX_LOCK && wb_dat_i[LOCK_BIT])
			lock_seen_q <= 1'b1;
	end
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_pulse;
		wb_ack_o ##1 !wb_ack_o;
	endsequence

	// ==========================================
	// Assertions
	AST_ACK_ONCE: assert property (s_req |=> s_pulse) else $error("ack not a single pulse");
	AST_ACK_SRC: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
	AST_DAT_HI: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("read upper bits set");
	AST_RST_QUIET: assert property ($past(rst_i) |-> !wb_ack_o && !full_speed_o && fan_min_run_o == 3'h0
		&& !xor_test_on_o) else $error("outputs active after reset");
	AST_FS_RISE: assert property ($rose(full_speed_o) |-> $past(|temp_valid_i, 2)) else $error("override rose without sample");
	AST_FS_FALL: assert property ($fell(full_speed_o) |-> $past(|temp_valid_i, 2) || $past(wr, 2)
		|| $past(wr, 3)) else $error("override fell without cause");
	AST_FAN_CHG: assert property ($changed(fan_min_run_o) |-> $past(|temp_valid_i, 2)) else $error("fan changed without sample");
	AST_XOR_CHG: assert property ($changed(xor_test_on_o) |-> $past(wr) || $past(wr, 2)) else $error("test mode changed without write");
	AST_XOR_LOCKED: assert property (lock_seen_q |=> $stable(xor_test_on_o)) else $error("test mode changed while locked");
endmodule

bind tfs_regs tfs_regs_checker #(.ADR_W(ADR_W)) u_chk (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .temp_i(temp_i), .temp_valid_i(temp_valid_i), .fan_start_i(fan_start_i),
	.full_speed_o(full_speed_o), .fan_min_run_o(fan_min_run_o), .xor_test_on_o(xor_test_on_o)
);

// ### verification/tb.sv
`timescale 1ns/1ps

module tb;
	import tfs_pkg::*;
	logic        clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, full_speed, xor_on;
	logic [8:0]  wb_adr;
	logic [3:0]  wb_sel;
	logic [31:0] wb_wdat, wb_rdat, rd_q;
	logic [23:0] temp, fan_start;
	logic [2:0]  tvalid, fan_run;
	int          err_count, n_compared;
	logic [6:0]  lidx [7] = '{IDX_LIMIT_R1, IDX_LIMIT_LOC, IDX_LIMIT_R2, IDX_XOR_TEST, IDX_OFS_R1, IDX_OFS_LOC, IDX_OFS_R2};
	logic [7:0]  lexp [7] = '{8'h64, 8'h64, 8'h80, 8'h01, 8'hfe, 8'h03, 8'h05};
	logic [7:0]  rv [9] = '{8'h64, 8'h64, 8'h64, 8'h44, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00};

	tfs_regs u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
		.wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
		.temp_i(temp), .temp_valid_i(tvalid), .fan_start_i(fan_start), .full_speed_o(full_speed),
		.fan_min_run_o(fan_run), .xor_test_on_o(xor_on));

	initial begin
		clk_i = 0;
		forever #2 clk_i = ~clk_i;
	end

	task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Call right after a rising edge; request held until ack is sampled
	task automatic bus(logic we, logic [6:0] idx, logic [7:0] d);
		wb_cyc <= 1;
		wb_stb <= 1;
		wb_we <= we;
		wb_sel <= 4'h1;
		wb_adr <= {idx, 2'b00};
		wb_wdat <= {24'h0, d};
		do @(posedge clk_i); while (wb_ack !== 1'b1);
		rd_q = wb_rdat;
		wb_cyc <= 0;
		wb_stb <= 0;
		@(posedge clk_i);
	endtask

	task automatic rd(logic [6:0] idx, logic [7:0] exp);
		bus(0, idx, 8'h00);
		chk("register", {24'h0, exp}, rd_q);
	endtask

	task automatic samp(int ch, logic [7:0] v);
		temp[ch*8+:8] <= v;
		tvalid[ch] <= 1;
		@(posedge clk_i);
		tvalid <= 3'h0;
		repeat (3) @(posedge clk_i);
	endtask

	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk_i);
		err_count++;
		conclude();
	end

	initial begin
		{wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_wdat, temp, tvalid} = '0;
		fan_start = {8'h30, 8'h28, 8'h50};
		err_count = 0;
		n_compared = 0;
		rst_i = 1;
		repeat (8) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		for (int i = 0; i < 9; i++) rd(IDX_LIMIT_R1 + 7'(i), rv[i]);
		rd(7'h60, 8'h00);
		$display("test reset values done");
		wr_seq: begin
			bus(1, IDX_OFS_R1, 8'hfe);
			bus(1, IDX_OFS_LOC, 8'h03);
			bus(1, IDX_OFS_R2, 8'h05);
		end
		samp(0, 8'h20);
		rd(IDX_CORR_R1, 8'h1e);
		samp(1, 8'h7e);
		rd(IDX_CORR_LOC, 8'h7f);
		chk("full_speed", 1, full_speed);
		rd(IDX_STATUS, 8'h25);
		samp(1, 8'h5d);
		chk("full_speed", 1, full_speed);
		samp(1, 8'h5c);
		chk("full_speed", 0, full_speed);
		$display("test offset and override done");
		bus(1, IDX_LIMIT_R2, 8'h80);
		samp(2, 8'h70);
		chk("full_speed", 0, full_speed);
		bus(1, IDX_LIMIT_R2, 8'h40);
		samp(2, 8'h70);
		chk("full_speed", 1, full_speed);
		bus(1, IDX_LIMIT_R2, 8'h80);
		repeat (2) @(posedge clk_i);
		chk("full_speed", 0, full_speed);
		$display("test disable code done");
		bus(1, IDX_HYST_R1LOC, 8'h4f);
		rd(IDX_HYST_R1LOC, 8'h4f);
		samp(1, 8'h1b);
		chk("fan_run", 1, fan_run[1]);
		samp(1, 8'h16);
		chk("fan_run", 0, fan_run[1]);
		samp(1, 8'h25);
		chk("fan_run", 0, fan_run[1]);
		samp(1, 8'h26);
		chk("fan_run", 1, fan_run[1]);
		$display("test hysteresis done");
		bus(1, IDX_XOR_TEST, 8'h01);
		chk("xor_on", 1, xor_on);
		bus(1, IDX_XOR_TEST, 8'h00);
		chk("xor_on", 0, xor_on);
		bus(1, IDX_XOR_TEST, 8'h01);
		bus(1, IDX_LOCK, 8'h01);
		rd(IDX_LOCK, 8'h01);
		// Locked limit, test-enable and offset registers keep their values when written
		for (int i = 0; i < 7; i++) bus(1, lidx[i], (lidx[i] == IDX_XOR_TEST) ? 8'h00 : 8'h11);
		for (int i = 0; i < 7; i++) rd(lidx[i], lexp[i]);
		chk("xor_on", 1, xor_on);
		bus(1, IDX_HYST_R2, 8'h50);
		rd(IDX_HYST_R2, 8'h50);
		$display("test lock done");
		conclude();
	end
endmodule
